// ### core/usb_bdt_pkg.sv
`default_nettype none
package usb_bdt_pkg;

  // Shared RAM window in core data space
  localparam logic [11:0] RAM_BASE        = 12'h0400;
  localparam logic [11:0] RAM_LAST        = 12'h07FF;
  localparam logic [11:0] TABLE_LAST      = 12'h04FF;
  localparam int          RAM_BYTES       = 1024;
  localparam int          DESC_COUNT      = 64;
  localparam int          TABLE_MIN_BYTES = 8;

  // Register locations in core data space
  localparam logic [11:0] DEV_ADDR_REG    = 12'h0F40;
  localparam logic [11:0] FRAME_LOW_REG   = 12'h0F41;
  localparam logic [11:0] FRAME_HIGH_REG  = 12'h0F42;
  localparam logic [7:0]  DEV_ADDR_RESET  = 8'h00;
  localparam logic [10:0] FRAME_RESET     = 11'h000;

  // Byte positions inside one descriptor
  localparam logic [1:0]  DESC_STAT_OFS   = 2'h0;
  localparam logic [1:0]  DESC_CNT_OFS    = 2'h1;
  localparam logic [1:0]  DESC_ADL_OFS    = 2'h2;
  localparam logic [1:0]  DESC_ADH_OFS    = 2'h3;

  // Status byte fields
  localparam int          OWN_BIT         = 7;
  localparam int          KEEP_BIT        = 5;
  localparam int          STALL_BIT       = 2;
  localparam int          PID_LSB         = 2;
  localparam int          BC_HI_LSB       = 0;

  // Token packet identifiers
  localparam logic [3:0]  PID_OUT         = 4'h1;
  localparam logic [3:0]  PID_SOF         = 4'h5;
  localparam logic [3:0]  PID_IN          = 4'h9;
  localparam logic [3:0]  PID_SETUP       = 4'hD;

  localparam int          FIFO_DEPTH      = 4;

  typedef enum logic [1:0] {
    HS_NONE  = 2'b00,
    HS_ACK   = 2'b01,
    HS_NAK   = 2'b10,
    HS_STALL = 2'b11
  } handshake_e;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0000,
    ST_RD_STAT = 4'b0001,
    ST_RD_CNT  = 4'b0010,
    ST_RD_ADL  = 4'b0011,
    ST_RD_ADH  = 4'b0100,
    ST_DECIDE  = 4'b0101,
    ST_OUT     = 4'b0110,
    ST_DRAIN   = 4'b0111,
    ST_IN_ADDR = 4'b1000,
    ST_IN_DATA = 4'b1001,
    ST_IN_END  = 4'b1010,
    ST_WR_CNT  = 4'b1011,
    ST_WR_STAT = 4'b1100
  } engine_state_e;

  typedef struct packed {
    logic [3:0]  pid;
    logic [6:0]  addr;
    logic [3:0]  endp;
    logic [10:0] frame;
  } token_s;

  typedef struct packed {
    logic       last;
    logic [7:0] data;
  } data_word_s;

endpackage
`default_nettype wire

// ### core/usb_buffer_descriptor_ram.sv
`timescale 1ns/100ps
`default_nettype none

module byte_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      fill_r;
  logic             push;
  logic             pop;

  assign in_ready  = (fill_r != (AW+1)'(DEPTH));
  assign out_valid = (fill_r != '0);
  assign out_data  = mem[rd_ptr_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge core_clk)
  begin
    if (push)
    begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      fill_r   <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
      end
      fill_r <= fill_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// Contract
// - Address clears on bus reset or reset
// - Engine answers only tokens matching address
// - Frame number: low byte, three high bits
// - Frame pair loads on every SOF while USB is active
// - Frame registers ignore core writes
// - One kilobyte dual-port RAM at 400h-7FFh
// - First bank descriptors, rest endpoint data
// - Descriptor: status, count, address low, high
// - 32, 33 or 64 descriptors, 8-256 bytes
// - Descriptor used only when endpoint enabled
// - Descriptor bytes have no reset value
// - Status layout depends on current owner
// - Status bit 7 is the ownership semaphore
// - Engine writes token PID and actual count
// - Engine releases ownership unless keep, stall or OUT overflow
// - No blocking of core accesses to RAM
// - Keep flag holds ownership, suppresses completion
// - Stall flag answers STALL; SETUP releases it
module usb_buffer_descriptor_ram (
  input  wire logic                    core_clk,
  input  wire logic                    rst_n,
  input  wire logic                    usb_active,
  input  wire logic                    bus_reset_flag,
  input  wire logic [15:0]             endpoint_enable,
  input  wire logic [11:0]             cpu_addr,
  input  wire logic                    cpu_wr,
  input  wire logic [7:0]              cpu_wdata,
  output logic      [7:0]              cpu_rdata,
  input  wire logic                    tok_valid,
  input  wire usb_bdt_pkg::token_s     tok,
  input  wire logic                    rx_valid,
  input  wire usb_bdt_pkg::data_word_s rx_word,
  output logic                         rx_ready,
  output logic                         tx_valid,
  output usb_bdt_pkg::data_word_s      tx_word,
  input  wire logic                    tx_ready,
  output logic                         hs_valid,
  output usb_bdt_pkg::handshake_e      hs_code,
  output logic                         xfer_done,
  output logic      [5:0]              xfer_desc
);

  logic [7:0]                  ram [usb_bdt_pkg::RAM_BYTES];
  logic [7:0]                  dev_addr_r;
  logic [10:0]                 frame_r;
  logic [7:0]                  cpu_rdata_r;
  usb_bdt_pkg::engine_state_e  state_r;
  logic [5:0]                  desc_idx_r;
  logic [3:0]                  pid_r;
  logic [7:0]                  stat_r;
  logic [9:0]                  max_cnt_r;
  logic [7:0]                  adl_r;
  logic [9:0]                  buf_r;
  logic [9:0]                  xcnt_r;
  logic                        ovf_r;
  logic [7:0]                  eng_rdata_r;
  logic [9:0]                  eng_addr;
  logic                        eng_we;
  logic [7:0]                  eng_wdata;
  logic                        cpu_ram_hit;
  logic                        tok_hit;
  logic                        fifo_pop_ready;
  logic                        fifo_valid;
  usb_bdt_pkg::data_word_s     fifo_word;
  logic                        tx_valid_r;
  usb_bdt_pkg::data_word_s     tx_word_r;
  logic                        hs_valid_r;
  usb_bdt_pkg::handshake_e     hs_code_r;
  logic                        xfer_done_r;
  logic                        is_rx_pid;

  // Byte offset of one descriptor field inside the RAM
  function automatic logic [9:0] desc_ofs(input logic [5:0] idx, input logic [1:0] fld);
    desc_ofs = {2'b00, idx, fld};
  endfunction

  assign cpu_ram_hit = (cpu_addr >= usb_bdt_pkg::RAM_BASE) && (cpu_addr <= usb_bdt_pkg::RAM_LAST);
  assign tok_hit     = tok_valid && usb_active && (tok.pid != usb_bdt_pkg::PID_SOF)
                       && ({1'b0, tok.addr} == dev_addr_r);
  assign is_rx_pid   = (pid_r != usb_bdt_pkg::PID_IN);

  assign cpu_rdata = cpu_rdata_r;
  assign tx_valid  = tx_valid_r;
  assign tx_word   = tx_word_r;
  assign hs_valid  = hs_valid_r;
  assign hs_code   = hs_code_r;
  assign xfer_done = xfer_done_r;
  assign xfer_desc = desc_idx_r;

  // Device address register
  always_ff @(posedge core_clk)
  begin
    if (!rst_n || bus_reset_flag)
    begin
      dev_addr_r <= usb_bdt_pkg::DEV_ADDR_RESET;
    end
    else if (cpu_wr && (cpu_addr == usb_bdt_pkg::DEV_ADDR_REG))
    begin
      dev_addr_r <= cpu_wdata;
    end
  end

  // Frame number, loaded only from SOF tokens
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      frame_r <= usb_bdt_pkg::FRAME_RESET;
    end
    else if (tok_valid && usb_active && (tok.pid == usb_bdt_pkg::PID_SOF))
    begin
      frame_r <= tok.frame;
    end
  end

  // Shared RAM, no reset; core port never waits on the engine
  always_ff @(posedge core_clk)
  begin
    if (cpu_wr && cpu_ram_hit)
    begin
      ram[cpu_addr[9:0]] <= cpu_wdata;
    end
    if (eng_we)
    begin
      ram[eng_addr] <= eng_wdata;
    end
  end

  // Core read port
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      cpu_rdata_r <= 8'h00;
    end
    else if (cpu_ram_hit)
    begin
      cpu_rdata_r <= ram[cpu_addr[9:0]];
    end
    else if (cpu_addr == usb_bdt_pkg::DEV_ADDR_REG)
    begin
      cpu_rdata_r <= dev_addr_r;
    end
    else if (cpu_addr == usb_bdt_pkg::FRAME_LOW_REG)
    begin
      cpu_rdata_r <= frame_r[7:0];
    end
    else if (cpu_addr == usb_bdt_pkg::FRAME_HIGH_REG)
    begin
      cpu_rdata_r <= {5'b00000, frame_r[10:8]};
    end
    else
    begin
      cpu_rdata_r <= 8'h00;
    end
  end

  // Engine read port
  always_ff @(posedge core_clk)
  begin
    eng_rdata_r <= ram[eng_addr];
  end

  byte_fifo #(
    .WIDTH ($bits(usb_bdt_pkg::data_word_s)),
    .DEPTH (usb_bdt_pkg::FIFO_DEPTH)
  ) u_rx_fifo (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .in_valid  (rx_valid),
    .in_data   (rx_word),
    .in_ready  (rx_ready),
    .out_valid (fifo_valid),
    .out_data  (fifo_word),
    .out_ready (fifo_pop_ready)
  );

  assign fifo_pop_ready = (state_r == usb_bdt_pkg::ST_OUT) || (state_r == usb_bdt_pkg::ST_DRAIN);

  // Engine RAM address and write
  always_comb
  begin
    eng_addr  = buf_r + xcnt_r;
    eng_we    = 1'b0;
    eng_wdata = fifo_word.data;
    case (state_r)
      usb_bdt_pkg::ST_RD_STAT: eng_addr = desc_ofs(desc_idx_r, usb_bdt_pkg::DESC_STAT_OFS);
      usb_bdt_pkg::ST_RD_CNT:  eng_addr = desc_ofs(desc_idx_r, usb_bdt_pkg::DESC_CNT_OFS);
      usb_bdt_pkg::ST_RD_ADL:  eng_addr = desc_ofs(desc_idx_r, usb_bdt_pkg::DESC_ADL_OFS);
      usb_bdt_pkg::ST_RD_ADH:  eng_addr = desc_ofs(desc_idx_r, usb_bdt_pkg::DESC_ADH_OFS);
      usb_bdt_pkg::ST_OUT:
      begin
        eng_we = fifo_valid && !fifo_word.last && (xcnt_r < max_cnt_r);
      end
      usb_bdt_pkg::ST_WR_CNT:
      begin
        eng_addr  = desc_ofs(desc_idx_r, usb_bdt_pkg::DESC_CNT_OFS);
        eng_we    = 1'b1;
        eng_wdata = xcnt_r[7:0];
      end
      usb_bdt_pkg::ST_WR_STAT:
      begin
        eng_addr  = desc_ofs(desc_idx_r, usb_bdt_pkg::DESC_STAT_OFS);
        eng_we    = 1'b1;
        eng_wdata = 8'h00;
        eng_wdata[usb_bdt_pkg::OWN_BIT] = stat_r[usb_bdt_pkg::KEEP_BIT];
        eng_wdata[usb_bdt_pkg::PID_LSB +: 4] = pid_r;
        eng_wdata[usb_bdt_pkg::BC_HI_LSB +: 2] = xcnt_r[9:8];
      end
      default:
      begin
        eng_we = 1'b0;
      end
    endcase
  end

  // Engine sequencer
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      state_r     <= usb_bdt_pkg::ST_IDLE;
      desc_idx_r  <= 6'h00;
      pid_r       <= 4'h0;
      stat_r      <= 8'h00;
      max_cnt_r   <= 10'h000;
      adl_r       <= 8'h00;
      buf_r       <= 10'h000;
      xcnt_r      <= 10'h000;
      ovf_r       <= 1'b0;
      tx_valid_r  <= 1'b0;
      tx_word_r   <= '0;
      hs_valid_r  <= 1'b0;
      hs_code_r   <= usb_bdt_pkg::HS_NONE;
      xfer_done_r <= 1'b0;
    end
    else
    begin
      hs_valid_r  <= 1'b0;
      xfer_done_r <= 1'b0;
      case (state_r)
        usb_bdt_pkg::ST_IDLE:
        begin
          xcnt_r <= 10'h000;
          ovf_r  <= 1'b0;
          if (tok_hit && endpoint_enable[tok.endp])
          begin
            pid_r    <= tok.pid;
            desc_idx_r <= {1'b0, tok.endp, tok.pid == usb_bdt_pkg::PID_IN};
            state_r  <= usb_bdt_pkg::ST_RD_STAT;
          end
        end
        usb_bdt_pkg::ST_RD_STAT: state_r <= usb_bdt_pkg::ST_RD_CNT;
        usb_bdt_pkg::ST_RD_CNT:
        begin
          stat_r  <= eng_rdata_r;
          state_r <= usb_bdt_pkg::ST_RD_ADL;
        end
        usb_bdt_pkg::ST_RD_ADL:
        begin
          max_cnt_r <= {stat_r[usb_bdt_pkg::BC_HI_LSB +: 2], eng_rdata_r};
          state_r   <= usb_bdt_pkg::ST_RD_ADH;
        end
        usb_bdt_pkg::ST_RD_ADH:
        begin
          adl_r   <= eng_rdata_r;
          state_r <= usb_bdt_pkg::ST_DECIDE;
        end
        usb_bdt_pkg::ST_DECIDE:
        begin
          buf_r <= {eng_rdata_r[1:0], adl_r};
          if (!stat_r[usb_bdt_pkg::OWN_BIT])
          begin
            hs_valid_r <= 1'b1;
            hs_code_r  <= usb_bdt_pkg::HS_NAK;
            state_r    <= is_rx_pid ? usb_bdt_pkg::ST_DRAIN : usb_bdt_pkg::ST_IDLE;
          end
          else if (stat_r[usb_bdt_pkg::STALL_BIT] && (pid_r != usb_bdt_pkg::PID_SETUP))
          begin
            hs_valid_r <= 1'b1;
            hs_code_r  <= usb_bdt_pkg::HS_STALL;
            state_r    <= is_rx_pid ? usb_bdt_pkg::ST_DRAIN : usb_bdt_pkg::ST_IDLE;
          end
          else if (is_rx_pid)
          begin
            if ((pid_r == usb_bdt_pkg::PID_SETUP) && stat_r[usb_bdt_pkg::STALL_BIT])
            begin
              stat_r[usb_bdt_pkg::KEEP_BIT] <= 1'b0;
            end
            state_r <= usb_bdt_pkg::ST_OUT;
          end
          else
          begin
            state_r <= usb_bdt_pkg::ST_IN_ADDR;
          end
        end
        usb_bdt_pkg::ST_OUT:
        begin
          if (fifo_valid)
          begin
            if (fifo_word.last)
            begin
              hs_valid_r <= 1'b1;
              hs_code_r  <= ovf_r ? usb_bdt_pkg::HS_NAK : usb_bdt_pkg::HS_ACK;
              state_r    <= ovf_r ? usb_bdt_pkg::ST_IDLE : usb_bdt_pkg::ST_WR_CNT;
            end
            else if (xcnt_r < max_cnt_r)
            begin
              xcnt_r <= xcnt_r + 10'h001;
            end
            else
            begin
              ovf_r <= 1'b1;
            end
          end
        end
        usb_bdt_pkg::ST_DRAIN:
        begin
          if (fifo_valid && fifo_word.last)
          begin
            state_r <= usb_bdt_pkg::ST_IDLE;
          end
        end
        usb_bdt_pkg::ST_IN_ADDR:
        begin
          state_r <= (xcnt_r == max_cnt_r) ? usb_bdt_pkg::ST_IN_END : usb_bdt_pkg::ST_IN_DATA;
        end
        usb_bdt_pkg::ST_IN_DATA:
        begin
          if (!tx_valid_r)
          begin
            tx_valid_r <= 1'b1;
            tx_word_r  <= '{last: 1'b0, data: eng_rdata_r};
          end
          else if (tx_ready)
          begin
            tx_valid_r <= 1'b0;
            xcnt_r     <= xcnt_r + 10'h001;
            state_r    <= usb_bdt_pkg::ST_IN_ADDR;
          end
        end
        usb_bdt_pkg::ST_IN_END:
        begin
          if (!tx_valid_r)
          begin
            tx_valid_r <= 1'b1;
            tx_word_r  <= '{last: 1'b1, data: 8'h00};
          end
          else if (tx_ready)
          begin
            tx_valid_r <= 1'b0;
            state_r    <= usb_bdt_pkg::ST_WR_CNT;
          end
        end
        usb_bdt_pkg::ST_WR_CNT: state_r <= usb_bdt_pkg::ST_WR_STAT;
        usb_bdt_pkg::ST_WR_STAT:
        begin
          xfer_done_r <= !stat_r[usb_bdt_pkg::KEEP_BIT];
          state_r     <= usb_bdt_pkg::ST_IDLE;
        end
        default: state_r <= usb_bdt_pkg::ST_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_addr_bus_reset: assert property (bus_reset_flag |=> dev_addr_r == 8'h00)
    else $error("device address not cleared by bus reset");
  a_addr_mismatch: assert property (
    (state_r == usb_bdt_pkg::ST_IDLE) && tok_valid && ({1'b0, tok.addr} != dev_addr_r)
    |=> state_r == usb_bdt_pkg::ST_IDLE)
    else $error("engine took a token for another address");
  a_frame_sof_load: assert property (
    tok_valid && usb_active && tok.pid == usb_bdt_pkg::PID_SOF |=> frame_r == $past(tok.frame))
    else $error("frame number not loaded on SOF");
  a_frame_read_only: assert property (
    !(tok_valid && tok.pid == usb_bdt_pkg::PID_SOF) |=> $stable(frame_r))
    else $error("frame number changed without SOF");
  a_disabled_ignored: assert property (
    (state_r == usb_bdt_pkg::ST_IDLE) && tok_hit && !endpoint_enable[tok.endp]
    |=> state_r == usb_bdt_pkg::ST_IDLE)
    else $error("engine used descriptor of disabled endpoint");
  a_status_writeback: assert property (
    state_r == usb_bdt_pkg::ST_WR_STAT |-> eng_we && eng_wdata[5:2] == pid_r
    && eng_wdata[1:0] == xcnt_r[9:8] && $past(state_r) == usb_bdt_pkg::ST_WR_CNT)
    else $error("status byte not written with PID and count");
  a_own_release: assert property (
    state_r == usb_bdt_pkg::ST_WR_STAT && !stat_r[5] |-> !eng_wdata[7] ##1 xfer_done_r)
    else $error("ownership not released at completion");
  a_keep_held: assert property (
    state_r == usb_bdt_pkg::ST_WR_STAT && stat_r[5] |-> eng_wdata[7] ##1 !xfer_done_r)
    else $error("keep-owned descriptor released or reported");
  a_stall_answer: assert property (
    state_r == usb_bdt_pkg::ST_DECIDE && stat_r[7] && stat_r[2] && pid_r != usb_bdt_pkg::PID_SETUP
    |=> hs_valid_r && hs_code_r == usb_bdt_pkg::HS_STALL ##[1:8] state_r == usb_bdt_pkg::ST_IDLE)
    else $error("stalled descriptor not answered with STALL");

endmodule
`default_nettype wire

// ### verif/usb_host_model.sv
`timescale 1ns/100ps
`default_nettype none

module usb_host_model (
  input  wire logic                    core_clk,
  input  wire logic                    slow_ready,
  output logic                         tok_valid,
  output usb_bdt_pkg::token_s          tok,
  output logic                         rx_valid,
  output usb_bdt_pkg::data_word_s      rx_word,
  input  wire logic                    rx_ready,
  input  wire logic                    tx_valid,
  input  wire usb_bdt_pkg::data_word_s tx_word,
  output logic                         tx_ready
);
  logic [7:0] txq [$];
  logic [1:0] cyc = 2'h0;

  initial
  begin
    tok_valid = 1'b0;
    tok = '0;
    rx_valid = 1'b0;
    rx_word = '0;
    tx_ready = 1'b0;
  end

  // Ready every cycle, or one cycle in four when stalling
  always @(posedge core_clk)
  begin
    cyc <= #1 cyc + 2'h1;
    tx_ready <= #1 !slow_ready || (cyc == 2'h3);
    if (tx_valid === 1'b1 && tx_ready === 1'b1 && tx_word.last === 1'b0)
      txq.push_back(tx_word.data);
  end

  // One-cycle token, fields scrambled afterwards
  task automatic send_token(input logic [3:0] pid, input logic [6:0] addr,
                            input logic [3:0] endp, input logic [10:0] frame);
    tok_valid = 1'b1;
    tok = '{pid: pid, addr: addr, endp: endp, frame: frame};
    @(posedge core_clk);
    #1;
    tok_valid = 1'b0;
    tok = ~tok;
  endtask

  // Data words then end marker, each held until accepted
  task automatic send_data(input logic [7:0] q [$]);
    for (int i = 0; i <= q.size(); i++)
    begin
      rx_valid = 1'b1;
      rx_word = '{last: (i == q.size()), data: (i < q.size()) ? q[i] : 8'h00};
      do
        @(negedge core_clk);
      while (rx_ready !== 1'b1);
      @(posedge core_clk);
      #1;
    end
    rx_valid = 1'b0;
    rx_word = ~rx_word;
  endtask
endmodule

`default_nettype wire

// ### verif/usb_buffer_descriptor_ram_bench.sv
`timescale 1ns/100ps
`default_nettype none

module usb_buffer_descriptor_ram_bench;
  logic                    core_clk, rst_n, usb_active, bus_reset_flag, slow_ready;
  logic [15:0]             endpoint_enable;
  logic [11:0]             cpu_addr;
  logic                    cpu_wr, tok_valid, rx_valid, rx_ready, tx_valid, tx_ready;
  logic [7:0]              cpu_wdata, cpu_rdata;
  usb_bdt_pkg::token_s     tok;
  usb_bdt_pkg::data_word_s rx_word, tx_word;
  logic                    hs_valid, xfer_done;
  usb_bdt_pkg::handshake_e hs_code;
  logic [5:0]              xfer_desc, last_desc;
  logic [1:0]              last_hs;
  int                      ram_m [1024];
  int                      dev_m, n_mismatch, checks_done, cycles, hs_n, done_n, f;
  int                      seed = 32'hd82a_0c8a;
  int                      ram_a [6] = '{'h3ff, 'h400, 'h4ff, 'h500, 'h7ff, 'h800};
  // pid, endpoint, status, count, bytes, other address, enabled, active
  int                      tbl [11][8] = '{
    '{1, 1, 'h80, 8, 6, 0, 1, 1}, '{9, 1, 'h80, 5, 0, 0, 1, 1},
    '{1, 2, 'h00, 8, 3, 0, 1, 1}, '{1, 1, 'h80, 2, 4, 0, 1, 1},
    '{9, 3, 'h84, 4, 0, 0, 1, 1}, '{'hd, 0, 'h84, 8, 8, 0, 1, 1},
    '{1, 0, 'ha0, 8, 3, 0, 1, 1}, '{1, 4, 'h80, 0, 0, 0, 1, 1},
    '{9, 5, 'h80, 3, 0, 1, 1, 1}, '{9, 6, 'h80, 3, 0, 0, 0, 1},
    '{9, 7, 'h80, 3, 0, 0, 1, 0}};

  usb_buffer_descriptor_ram u_dut (
    .core_clk, .rst_n, .usb_active, .bus_reset_flag, .endpoint_enable,
    .cpu_addr, .cpu_wr, .cpu_wdata, .cpu_rdata, .tok_valid, .tok,
    .rx_valid, .rx_word, .rx_ready, .tx_valid, .tx_word, .tx_ready,
    .hs_valid, .hs_code, .xfer_done, .xfer_desc
  );

  usb_host_model u_host (
    .core_clk, .slow_ready, .tok_valid, .tok, .rx_valid, .rx_word,
    .rx_ready, .tx_valid, .tx_word, .tx_ready
  );

  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
  begin
    cycles++;
    if (hs_valid === 1'b1)
    begin
      hs_n++;
      last_hs = hs_code;
    end
    if (xfer_done === 1'b1)
    begin
      done_n++;
      last_desc = xfer_desc;
    end
    if (cycles == 30000)
    begin
      n_mismatch++;
      end_sim();
    end
  end

  task automatic end_sim();
    if (n_mismatch == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string name, input int exp, input logic [10:0] got);
    checks_done++;
    if (got !== exp[10:0])
    begin
      n_mismatch++;
      $display("FAIL %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  task automatic wr(input int a, input int d);
    cpu_addr = a[11:0];
    cpu_wr = 1'b1;
    cpu_wdata = d[7:0];
    @(posedge core_clk);
    #1;
    if (a >= 'h400 && a <= 'h7ff) ram_m[a - 'h400] = d & 'hff;
    if (a == usb_bdt_pkg::DEV_ADDR_REG) dev_m = d & 'hff;
  endtask

  task automatic rdchk(input string name, input int a, input int exp);
    cpu_addr = a[11:0];
    cpu_wr = 1'b0;
    @(posedge core_clk);
    #1;
    chk(name, exp, {3'b000, cpu_rdata});
  endtask

  task automatic idle(input int n);
    cpu_wr = 1'b0;
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic xact(input int pid, endp, stat, cnt, nb, wrong, en, act);
    int         idx, b, n, exp_hs, exp_done, keep, take, txn, ovf;
    logic [7:0] q [$];
    idx = endp * 2 + (pid == 9);
    b = 'h100 + ($random(seed) & 'h2f0);
    slow_ready = $random(seed) & 1;
    for (int i = 0; i < 16; i++) wr('h400 + b + i, $random(seed));
    for (int i = 0; i < nb; i++) q.push_back($random(seed));
    wr('h401 + idx * 4, cnt);
    wr('h402 + idx * 4, b);
    wr('h403 + idx * 4, 4 + (b >> 8));
    wr('h400 + idx * 4, stat);
    if (pid == 9) wr('h400 + b, 'h5a);
    rdchk("stat_read", 'h400 + idx * 4, stat);
    endpoint_enable = 16'(en) << endp;
    usb_active = act[0];
    u_host.txq.delete();
    hs_n = 0;
    done_n = 0;
    take = act && en && !wrong;
    u_host.send_token(pid[3:0], wrong ? 7'(dev_m + 1) : 7'(dev_m), endp[3:0], 11'h000);
    if (take && pid != 9) u_host.send_data(q);
    for (int i = 0; i < 150 && hs_n + done_n == 0; i++) @(posedge core_clk);
    repeat (4) @(posedge core_clk);
    #1;
    exp_hs = 0;
    exp_done = 0;
    txn = 0;
    ovf = pid != 9 && nb > cnt;
    if (take && !stat[7]) exp_hs = 2;
    else if (take && stat[2] && pid != 'hd) exp_hs = 3;
    else if (take && ovf) exp_hs = 2;
    else if (take)
    begin
      n = pid == 9 ? cnt : nb;
      keep = stat[5] && !stat[2];
      exp_hs = pid != 9;
      exp_done = !keep;
      txn = pid == 9 ? n : 0;
      for (int i = 0; i < n && pid != 9; i++) ram_m[b + i] = q[i];
      ram_m[idx * 4 + 1] = n & 'hff;
      ram_m[idx * 4] = (keep << 7) | (pid << 2) | (n >> 8);
    end
    chk("hs_count", exp_hs != 0, hs_n);
    if (exp_hs != 0) chk("hs_code", exp_hs, last_hs);
    chk("done_count", exp_done, done_n);
    if (exp_done) chk("done_desc", idx, last_desc);
    chk("tx_len", txn, u_host.txq.size());
    for (int i = 0; i < txn && i < u_host.txq.size(); i++)
      chk("tx_byte", ram_m[b + i], u_host.txq[i]);
    for (int i = 0; i < 2; i++)
      rdchk("descriptor", 'h400 + idx * 4 + i, ram_m[idx * 4 + i]);
    for (int i = 0; i < 16 && !ovf; i++)
      rdchk("buffer", 'h400 + b + i, ram_m[b + i]);
    usb_active = 1'b1;
  endtask

  initial
  begin
    {rst_n, bus_reset_flag, cpu_wr, slow_ready} = '0;
    usb_active = 1'b1;
    endpoint_enable = '0;
    cpu_addr = '0;
    cpu_wdata = '0;
    repeat (12) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    rdchk("addr_reset", usb_bdt_pkg::DEV_ADDR_REG, 0);
    rdchk("frame_reset", usb_bdt_pkg::FRAME_LOW_REG, 0);
    rdchk("unmapped", 'h100, 0);
    wr(usb_bdt_pkg::DEV_ADDR_REG, 'h3c);
    rdchk("addr_rw", usb_bdt_pkg::DEV_ADDR_REG, 'h3c);
    bus_reset_flag = 1'b1;
    idle(1);
    bus_reset_flag = 1'b0;
    rdchk("addr_busreset", usb_bdt_pkg::DEV_ADDR_REG, 0);
    wr(usb_bdt_pkg::DEV_ADDR_REG, 'h15);
    rst_n = 1'b0;
    idle(2);
    rst_n = 1'b1;
    rdchk("addr_corereset", usb_bdt_pkg::DEV_ADDR_REG, 0);
    for (int k = 0; k < 4; k++)
    begin
      f = $random(seed) & 'h7ff;
      u_host.send_token(usb_bdt_pkg::PID_SOF, 7'(k * 37), 4'h0, f[10:0]);
      rdchk("frame_low", usb_bdt_pkg::FRAME_LOW_REG, f & 'hff);
      rdchk("frame_high", usb_bdt_pkg::FRAME_HIGH_REG, f >> 8);
      wr(usb_bdt_pkg::FRAME_LOW_REG + (k & 1), ~f);
    end
    rdchk("frame_ro_low", usb_bdt_pkg::FRAME_LOW_REG, f & 'hff);
    rdchk("frame_ro_high", usb_bdt_pkg::FRAME_HIGH_REG, f >> 8);
    foreach (ram_a[i]) wr(ram_a[i], $random(seed));
    foreach (ram_a[i])
      rdchk("ram", ram_a[i], (ram_a[i] >= 'h400 && ram_a[i] <= 'h7ff) ? ram_m[ram_a[i] - 'h400] : 0);
    wr(usb_bdt_pkg::DEV_ADDR_REG, $random(seed) & 'h7f);
    foreach (tbl[i])
      xact(tbl[i][0], tbl[i][1], tbl[i][2], tbl[i][3], tbl[i][4], tbl[i][5], tbl[i][6], tbl[i][7]);
    for (int k = 0; k < 6; k++)
    begin
      f = 1 + ($random(seed) & 7);
      xact(k[0] ? 9 : 1, $random(seed) & 15, 'h80, f, f, 0, 1, 1);
    end
    idle(2);
    end_sim();
  end
endmodule

`default_nettype wire
